/* File: aboe_map.vh */
/*
 * constants of the arithmetic and bit-operation execute block: operation
 * codes, special file register addresses, reset values and timing counts.
 * assumes it is included by its bare name from the design files.
 */
`ifndef ABOE_MAP_VH
`define ABOE_MAP_VH

// operation codes on op_code
`define ABOE_OP_NOP       3'h0
`define ABOE_OP_ADD_LIT   3'h1
`define ABOE_OP_ADD_REG   3'h2
`define ABOE_OP_AND_LIT   3'h3
`define ABOE_OP_AND_REG   3'h4
`define ABOE_OP_BIT_CLR   3'h5
`define ABOE_OP_BIT_SET   3'h6
`define ABOE_OP_SKIP_CLR  3'h7

// special file register addresses
`define ABOE_ADDR_TIMER   7'h01
`define ABOE_ADDR_PORT_A  7'h05

// destination select values
`define ABOE_DEST_ACC     1'b0
`define ABOE_DEST_FILE    1'b1

// reset values
`define ABOE_RST_BYTE     8'h00
`define ABOE_RST_FLAG     1'b0

// idle cycles after a skip that is taken
`define ABOE_SKIP_IDLE_CYCLES 1

`endif

/* File: aboe_core.v */
/*
 * execute stage for add/and with literal or file register, bit clear,
 * bit set and skip-if-bit-clear, with a 128-byte file register array.
 * assumes one instruction per accepted op_valid from a sequencer on the
 * same clock; port a pins arrive asynchronously and are synchronised here.
 */
`include "aboe_map.vh"

module aboe_core #(
  parameter DATA_W = 8,
  parameter ADDR_W = 7
) (
  // clock and reset
  input  wire              clock,
  input  wire              arst_n,
  // instruction request
  input  wire              op_valid,
  input  wire [2:0]        op_code,
  input  wire [ADDR_W-1:0] op_addr,
  input  wire [2:0]        op_bit,
  input  wire              op_dest,
  input  wire [DATA_W-1:0] op_literal,
  output reg               op_ready_r,
  output reg               op_done_r,
  output reg               skip_next_r,
  // configuration
  input  wire              prescaler_to_timer,
  // pins and peripheral side
  input  wire [DATA_W-1:0] port_a_pins,
  output reg  [DATA_W-1:0] port_a_latch_r,
  output reg  [DATA_W-1:0] timer_zero_count_r,
  output reg               prescaler_clear_r,
  // architectural state
  output reg  [DATA_W-1:0] acc_r,
  output reg               carry_flag_r,
  output reg               digit_carry_flag_r,
  output reg               zero_flag_r,
  // file register read-back
  input  wire [ADDR_W-1:0] peek_addr,
  output reg  [DATA_W-1:0] peek_data_r
);

  localparam DEPTH = 1 << ADDR_W;
  localparam [1:0] ST_EXEC = 2'b01;
  localparam [1:0] ST_IDLE = 2'b10;

  reg              rst_meta_r;
  reg              rst_sync_n_r;
  reg [DATA_W-1:0] pins_meta_r;
  reg [DATA_W-1:0] pins_sync_r;
  reg [DATA_W-1:0] file_r [0:DEPTH-1];
  reg [1:0]        state_r;
  reg [1:0]        state_nxt;
  integer          i;

  // reset release through two flops
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_r   <= 1'b0;
      rst_sync_n_r <= 1'b0;
    end else begin
      rst_meta_r   <= 1'b1;
      rst_sync_n_r <= rst_meta_r;
    end
  end

  // pins are asynchronous to the core clock
  always @(posedge clock or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      pins_meta_r <= `ABOE_RST_BYTE;
      pins_sync_r <= `ABOE_RST_BYTE;
    end else begin
      pins_meta_r <= port_a_pins;
      pins_sync_r <= pins_meta_r;
    end
  end

  wire take = op_valid & op_ready_r;

  // port a reads the pins so a pin held low by the outside world is
  // written back low even where its latch holds one
  reg [DATA_W-1:0] src_f;
  always @* begin
    if (op_addr == `ABOE_ADDR_PORT_A)
      src_f = pins_sync_r;
    else
      src_f = file_r[op_addr];
  end

  // adder shared by both add forms
  wire [DATA_W-1:0] add_b  = (op_code == `ABOE_OP_ADD_LIT) ?
                             op_literal : src_f;
  wire [DATA_W:0]   sum9   = {1'b0, acc_r} + {1'b0, add_b};
  wire [4:0]        sum_lo = {1'b0, acc_r[3:0]} + {1'b0, add_b[3:0]};
  wire [DATA_W-1:0] and_b  = (op_code == `ABOE_OP_AND_LIT) ?
                             op_literal : src_f;
  wire [DATA_W-1:0] and_v  = acc_r & and_b;
  wire [DATA_W-1:0] bit_m  = {{(DATA_W-1){1'b0}}, 1'b1} << op_bit;

  // combinational result selection
  reg [DATA_W-1:0] res;
  reg              wr_acc;
  reg              wr_file;
  reg              upd_cdc;
  reg              upd_z;
  reg              skip;
  always @* begin
    res     = acc_r;
    wr_acc  = 1'b0;
    wr_file = 1'b0;
    upd_cdc = 1'b0;
    upd_z   = 1'b0;
    skip    = 1'b0;
    case (op_code)
      `ABOE_OP_ADD_LIT: begin
        res     = sum9[DATA_W-1:0];
        wr_acc  = 1'b1;
        upd_cdc = 1'b1;
        upd_z   = 1'b1;
      end
      `ABOE_OP_ADD_REG: begin
        res     = sum9[DATA_W-1:0];
        wr_acc  = (op_dest == `ABOE_DEST_ACC);
        wr_file = (op_dest == `ABOE_DEST_FILE);
        upd_cdc = 1'b1;
        upd_z   = 1'b1;
      end
      `ABOE_OP_AND_LIT: begin
        res    = and_v;
        wr_acc = 1'b1;
        upd_z  = 1'b1;
      end
      `ABOE_OP_AND_REG: begin
        res     = and_v;
        wr_acc  = (op_dest == `ABOE_DEST_ACC);
        wr_file = (op_dest == `ABOE_DEST_FILE);
        upd_z   = 1'b1;
      end
      `ABOE_OP_BIT_CLR: begin
        res     = src_f & ~bit_m;
        wr_file = 1'b1;
      end
      `ABOE_OP_BIT_SET: begin
        res     = src_f | bit_m;
        wr_file = 1'b1;
      end
      `ABOE_OP_SKIP_CLR: begin
        skip = ~src_f[op_bit];
      end
      default: begin
        res = acc_r;
      end
    endcase
  end

  // a taken skip turns the following slot into an idle cycle
  always @* begin
    case (state_r)
      ST_EXEC: state_nxt = (take && skip) ? ST_IDLE : ST_EXEC;
      ST_IDLE: state_nxt = ST_EXEC;
      default: state_nxt = ST_EXEC;
    endcase
  end

  always @(posedge clock or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      state_r     <= ST_EXEC;
      op_ready_r  <= 1'b0;
      op_done_r   <= 1'b0;
      skip_next_r <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      op_ready_r  <= (state_nxt == ST_EXEC);
      op_done_r   <= take;
      skip_next_r <= take & skip;
    end
  end

  // architectural registers and flags
  always @(posedge clock or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      acc_r              <= `ABOE_RST_BYTE;
      carry_flag_r       <= `ABOE_RST_FLAG;
      digit_carry_flag_r <= `ABOE_RST_FLAG;
      zero_flag_r        <= `ABOE_RST_FLAG;
    end else if (take) begin
      if (wr_acc)
        acc_r <= res;
      if (upd_cdc) begin
        carry_flag_r       <= sum9[DATA_W];
        digit_carry_flag_r <= sum_lo[4];
      end
      if (upd_z)
        zero_flag_r <= (res == {DATA_W{1'b0}});
    end
  end

  // file register array with mirrored port a latch and timer count
  always @(posedge clock or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      for (i = 0; i < DEPTH; i = i + 1)
        file_r[i] <= `ABOE_RST_BYTE;
      port_a_latch_r     <= `ABOE_RST_BYTE;
      timer_zero_count_r <= `ABOE_RST_BYTE;
      prescaler_clear_r  <= 1'b0;
    end else begin
      prescaler_clear_r <= 1'b0;
      if (take && wr_file) begin
        file_r[op_addr] <= res;
        if (op_addr == `ABOE_ADDR_PORT_A)
          port_a_latch_r <= res;
        if (op_addr == `ABOE_ADDR_TIMER) begin
          timer_zero_count_r <= res;
          prescaler_clear_r  <= prescaler_to_timer;
        end
      end
    end
  end

  // peek shows pins at the port a address, as any read of it would
  always @(posedge clock or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r)
      peek_data_r <= `ABOE_RST_BYTE;
    else if (peek_addr == `ABOE_ADDR_PORT_A)
      peek_data_r <= pins_sync_r;
    else
      peek_data_r <= file_r[peek_addr];
  end

endmodule // aboe_core

/* File: aboe_core_sva.sv */
/* checker for aboe_core, watching only its ports.
   assumes the operation codes and addresses of aboe_map.vh */
`include "aboe_map.vh"
module aboe_sva (
  // clock and reset
  input logic       clock,
  input logic       arst_n,
  // handshake and flags
  input logic       op_valid,
  input logic       op_dest,
  input logic       op_ready_r,
  input logic       op_done_r,
  input logic       skip_next_r,
  input logic       prescaler_to_timer,
  input logic       prescaler_clear_r,
  input logic       carry_flag_r,
  input logic       digit_carry_flag_r,
  input logic       zero_flag_r,
  // request fields and state
  input logic [2:0] op_code,
  input logic [6:0] op_addr,
  input logic [7:0] op_literal,
  input logic [7:0] acc_r,
  input logic [7:0] timer_zero_count_r
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  wire tk  = op_valid && op_ready_r;
  wire lit = tk && op_code == `ABOE_OP_ADD_LIT;
  wire bop = tk && (op_code == `ABOE_OP_BIT_CLR ||
                    op_code == `ABOE_OP_BIT_SET);
  wire rop = op_code == `ABOE_OP_ADD_REG || op_code == `ABOE_OP_AND_REG;
  // only file-bound results touch the timer, so d=0 must not clear
  wire tw  = tk && op_addr == `ABOE_ADDR_TIMER && (bop || (rop && op_dest));
  sequence s_gap;
    op_done_r && !op_ready_r ##1 op_ready_r && !skip_next_r;
  endsequence
  a_add_lit_sum: assert property (lit |=>
    acc_r == $past(acc_r) + $past(op_literal)) else $error("add sum wrong");
  a_add_lit_carry: assert property (lit |=> carry_flag_r ==
    ({1'b0, $past(acc_r)} + $past(op_literal) > 9'h0ff)) else $error("carry");
  a_add_lit_dc: assert property (lit |=> digit_carry_flag_r ==
    ($past(acc_r[3:0]) + $past(op_literal[3:0]) > 5'h0f)) else $error("dc");
  a_and_lit_zero: assert property (
    tk && op_code == `ABOE_OP_AND_LIT |=>
    acc_r == ($past(acc_r) & $past(op_literal)) && zero_flag_r ==
    (acc_r == 8'h00) && $stable(carry_flag_r)) else $error("and literal");
  a_bit_flags_kept: assert property (bop |=>
    $stable({carry_flag_r, digit_carry_flag_r, zero_flag_r, acc_r}))
    else $error("bit op changed flags");
  a_timer_clear: assert property (tw |=>
    prescaler_clear_r == $past(prescaler_to_timer)) else $error("prescaler");
  a_timer_add: assert property (
    tk && op_code == `ABOE_OP_ADD_REG && op_dest &&
    op_addr == `ABOE_ADDR_TIMER |=> timer_zero_count_r ==
    $past(acc_r) + $past(timer_zero_count_r)) else $error("file add");
  a_skip_gap: assert property (skip_next_r |-> s_gap)
    else $error("skip idle cycle wrong");
  a_clear_only_timer: assert property (!tw |=> !prescaler_clear_r)
    else $error("prescaler cleared without timer write");
  a_and_reg_zero: assert property (
    tk && op_code == `ABOE_OP_AND_REG && op_dest == `ABOE_DEST_ACC |=>
    zero_flag_r == (acc_r == 8'h00) && $stable(carry_flag_r) &&
    $stable(digit_carry_flag_r)) else $error("and register flags");
  a_single_cycle: assert property (op_done_r && !skip_next_r |->
    op_ready_r) else $error("plain op stalled ready");
endmodule // aboe_sva
bind aboe_core aboe_sva u_sva (.clock, .arst_n, .op_valid, .op_dest,
  .op_ready_r, .op_done_r, .skip_next_r, .prescaler_to_timer,
  .prescaler_clear_r, .carry_flag_r, .digit_carry_flag_r, .zero_flag_r,
  .op_code, .op_addr, .op_literal, .acc_r, .timer_zero_count_r);

/* File: tb_top.sv */
/* bench for aboe_core: op calls with expected values.
   assumes the ready/done handshake of the design at 50 MHz */
`include "aboe_map.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clock = 1'b0, arst_n = 1'b0, op_valid = 1'b0, op_dest = 1'b0;
  logic       ptt = 1'b1, rdy, done, skip, pclr, c, dc, z;
  logic [2:0] op_code = 3'h0, op_bit = 3'h0;
  logic [6:0] op_addr = 7'h00, peek_addr = 7'h00;
  logic [7:0] op_literal = 8'h00, pins = 8'ha5, latch, tmr, acc, peek;
  integer     errors = 0, checked = 0;
  always #10 clock = ~clock;
  aboe_core dut (.clock, .arst_n, .op_valid, .op_code, .op_addr, .op_bit,
    .op_dest, .op_literal, .op_ready_r(rdy), .op_done_r(done),
    .skip_next_r(skip), .prescaler_to_timer(ptt), .port_a_pins(pins),
    .port_a_latch_r(latch), .timer_zero_count_r(tmr),
    .prescaler_clear_r(pclr), .acc_r(acc), .carry_flag_r(c),
    .digit_carry_flag_r(dc), .zero_flag_r(z), .peek_addr,
    .peek_data_r(peek));
  task test_done;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk8(input logic [7:0] g, input logic [7:0] e);
    checked = checked + 1;
    if (g !== e) begin
      errors = errors + 1;
      $display("FAIL %0t got %h expected %h", $time, g, e);
    end
  endtask
  // flags are packed as {carry, digit carry, zero}
  task flags(input logic [2:0] e);
    chk8({5'h00, c, dc, z}, {5'h00, e});
  endtask
  task op(input logic [2:0] cd, input logic [6:0] a, input logic [2:0] b,
          input logic d, input logic [7:0] k);
    integer n;
    n = 0;
    @(posedge clock);
    op_valid <= 1'b1;
    op_code <= cd;
    op_addr <= a;
    op_bit <= b;
    op_dest <= d;
    op_literal <= k;
    #1;
    while (rdy !== 1'b1 && n < 20) begin
      @(posedge clock);
      #1;
      n = n + 1;
    end
    if (rdy !== 1'b1) begin
      errors = errors + 1;
      $display("FAIL %0t ready timeout", $time);
      test_done;
    end
    @(posedge clock);
    op_valid <= 1'b0;
    #1;
    chk8({7'h00, done}, 8'h01);
  endtask
  task rd(input logic [6:0] a, input logic [7:0] e);
    @(posedge clock);
    peek_addr <= a;
    @(posedge clock);
    #1;
    chk8(peek, e);
  endtask
  initial begin
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    op(`ABOE_OP_ADD_LIT, 7'h00, 3'h0, 1'b0, 8'hff);
    flags(3'h0);
    op(`ABOE_OP_ADD_LIT, 7'h00, 3'h0, 1'b0, 8'h0b);
    chk8(acc, 8'h0a);
    flags(3'h6);
    op(`ABOE_OP_AND_LIT, 7'h00, 3'h0, 1'b0, 8'hf0);
    chk8(acc, 8'h00);
    flags(3'h7);
    op(`ABOE_OP_ADD_LIT, 7'h00, 3'h0, 1'b0, 8'h0a);
    op(`ABOE_OP_ADD_REG, 7'h7f, 3'h0, 1'b1, 8'h00);
    op(`ABOE_OP_ADD_REG, 7'h7f, 3'h0, 1'b0, 8'h00);
    chk8(acc, 8'h14);
    flags(3'h2);
    rd(7'h7f, 8'h0a);
    op(`ABOE_OP_AND_REG, 7'h7f, 3'h0, 1'b1, 8'h00);
    flags(3'h3);
    rd(7'h7f, 8'h00);
    op(`ABOE_OP_BIT_SET, 7'h7f, 3'h7, 1'b0, 8'h00);
    op(`ABOE_OP_BIT_SET, 7'h7f, 3'h0, 1'b0, 8'h00);
    rd(7'h7f, 8'h81);
    op(`ABOE_OP_BIT_CLR, 7'h7f, 3'h7, 1'b0, 8'h00);
    rd(7'h7f, 8'h01);
    flags(3'h3);
    op(`ABOE_OP_SKIP_CLR, 7'h7f, 3'h0, 1'b0, 8'h00);
    chk8({6'h00, skip, rdy}, 8'h01);
    op(`ABOE_OP_SKIP_CLR, 7'h7f, 3'h1, 1'b0, 8'h00);
    chk8({6'h00, skip, rdy}, 8'h02);
    op(`ABOE_OP_ADD_REG, 7'h01, 3'h0, 1'b1, 8'h00);
    chk8({pclr, tmr[6:0]}, 8'h94);
    op(`ABOE_OP_AND_REG, 7'h01, 3'h0, 1'b0, 8'h00);
    chk8({pclr, tmr[6:0]}, 8'h14);
    op(`ABOE_OP_BIT_CLR, 7'h05, 3'h0, 1'b0, 8'h00);
    chk8(latch, 8'ha4);
    op(`ABOE_OP_BIT_SET, 7'h05, 3'h1, 1'b0, 8'h00);
    chk8(latch, 8'ha7);
    rd(7'h05, 8'ha5);
    op(`ABOE_OP_NOP, 7'h00, 3'h0, 1'b0, 8'h00);
    chk8(acc, 8'h14);
    flags(3'h0);
    op(`ABOE_OP_ADD_LIT, 7'h00, 3'h0, 1'b0, 8'hec);
    chk8(acc, 8'h00);
    flags(3'h7);
    @(posedge clock);
    ptt <= 1'b0;
    op(`ABOE_OP_BIT_SET, 7'h01, 3'h7, 1'b0, 8'h00);
    chk8({pclr, tmr[6:0]}, 8'h14);
    chk8(tmr, 8'h94);
    test_done;
  end
endmodule // tb_top
